// [logic/ppei_pkg.sv]
package ppei_pkg;
  // ----------------------------------------
  // Register map (word index, byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_FIRST_FLAGS = 8'h89;
  localparam logic [7:0] IDX_SECOND_FLAGS = 8'h8A;
  localparam logic [7:0] IDX_THIRD_FLAGS = 8'h8B;
  localparam logic [7:0] IDX_CONTROL = 8'h8C;
  localparam logic [7:0] IDX_SECOND_MASK = 8'h8D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int BIT_FIRST_EDGE = 0;
  localparam int BIT_SECOND_EDGE = 1;
  localparam int BIT_THIRD_EDGE = 2;
  localparam int BIT_FIRST_LO_EN = 3;
  localparam int BIT_FIRST_HI_EN = 4;
  localparam int BIT_THIRD_EN = 5;
  localparam logic [7:0] CONTROL_WMASK = 8'h7F;
  localparam logic [7:0] THIRD_FLAG_MASK = 8'h1F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_IRQ = 3'h0;
endpackage : ppei_pkg

// [logic/ppei_port_if.sv]
`timescale 1ns/100ps
interface ppei_port_if;
  logic [7:0] pins;
  logic falling;
  logic [7:0] enable;
  logic [7:0] hits;
  modport det (input pins, input falling, input enable, output hits);
  modport ctl (output pins, output falling, output enable, input hits);
endinterface : ppei_port_if

// [logic/ppei_edge_det.sv]
`timescale 1ns/100ps
module ppei_edge_det
  import ppei_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Sync reset
  ppei_port_if.det port // Pins, edge select, enables, hits
);
  logic [7:0] last;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last <= RESET_BYTE;
    end else begin
      last <= port.pins;
    end
  end

  // Selected edge, gated by enables
  assign port.hits = (port.falling ? (last & ~port.pins) : (~last & port.pins)) & port.enable;
endmodule : ppei_edge_det

// [logic/ppei_top.sv]
`timescale 1ns/100ps
module ppei_top
  import ppei_pkg::*;
(
  input wire logic clk, // System clock 25 MHz
  input wire logic rst_b, // Sync reset, active low
  input wire logic [9:0] avs_address, // Word address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic [7:0] first_port_pins, // Port 0 inputs
  input wire logic [7:0] second_port_pins, // Port 1 inputs
  input wire logic [4:0] third_port_pins, // Port 2 inputs
  output logic first_port_irq, // Port 0 request
  output logic second_port_irq, // Port 1 request
  output logic third_port_irq, // Port 2 request
  output logic irq // Masked summary interrupt
);
  logic [7:0] port_interrupt_control;
  logic [7:0] second_port_pin_interrupt_mask;
  logic [7:0] first_port_pending_flags;
  logic [7:0] second_port_pending_flags;
  logic [7:0] third_port_pending_flags;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic done;
  logic [7:0] next_rdata;

  ppei_port_if p0 ();
  ppei_port_if p1 ();
  ppei_port_if p2 ();

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  assign p0.pins = first_port_pins;
  assign p1.pins = second_port_pins;
  assign p2.pins = {3'h0, third_port_pins};
  assign p0.falling = port_interrupt_control[BIT_FIRST_EDGE];
  assign p1.falling = port_interrupt_control[BIT_SECOND_EDGE];
  assign p2.falling = port_interrupt_control[BIT_THIRD_EDGE];
  assign p0.enable = {{4{port_interrupt_control[BIT_FIRST_HI_EN]}},
                      {4{port_interrupt_control[BIT_FIRST_LO_EN]}}};
  assign p1.enable = second_port_pin_interrupt_mask;
  assign p2.enable = {8{port_interrupt_control[BIT_THIRD_EN]}} & THIRD_FLAG_MASK;

  ppei_edge_det u_det0 (.clk(clk), .rst_b(rst_b), .port(p0.det));
  ppei_edge_det u_det1 (.clk(clk), .rst_b(rst_b), .port(p1.det));
  ppei_edge_det u_det2 (.clk(clk), .rst_b(rst_b), .port(p2.det));

  // ----------------------------------------
  // Bus access
  // ----------------------------------------
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    return a == {2'h0, idx};
  endfunction : hit

  logic wr_lane0;
  assign wr_lane0 = avs_write && !done && avs_byteenable[0];

  // One wait state per access, answer on second cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done <= 1'b0;
    end else begin
      done <= (avs_read || avs_write) && !done;
    end
  end

  // Stall kept in its own flop, the inverse of done, so the output is registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !done);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port_interrupt_control <= RESET_BYTE;
      second_port_pin_interrupt_mask <= RESET_BYTE;
      irq_mask <= RESET_IRQ;
    end else if (wr_lane0) begin
      if (hit(avs_address, IDX_CONTROL)) port_interrupt_control <= avs_writedata[7:0] & CONTROL_WMASK;
      if (hit(avs_address, IDX_SECOND_MASK)) second_port_pin_interrupt_mask <= avs_writedata[7:0];
      if (hit(avs_address, IDX_IRQ_MASK)) irq_mask <= avs_writedata[2:0];
    end
  end

  // ----------------------------------------
  // Pending flags: set wins over write-0 clear
  // ----------------------------------------
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] hits, input logic wr,
                                     input logic [7:0] wd);
    return (wr ? (cur & wd) : cur) | hits;
  endfunction : upd

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_port_pending_flags <= RESET_BYTE;
      second_port_pending_flags <= RESET_BYTE;
      third_port_pending_flags <= RESET_BYTE;
    end else begin
      first_port_pending_flags <= upd(first_port_pending_flags, p0.hits,
        wr_lane0 && hit(avs_address, IDX_FIRST_FLAGS), avs_writedata[7:0]);
      second_port_pending_flags <= upd(second_port_pending_flags, p1.hits,
        wr_lane0 && hit(avs_address, IDX_SECOND_FLAGS), avs_writedata[7:0]);
      third_port_pending_flags <= upd(third_port_pending_flags, p2.hits,
        wr_lane0 && hit(avs_address, IDX_THIRD_FLAGS), avs_writedata[7:0]) & THIRD_FLAG_MASK;
    end
  end

  // ----------------------------------------
  // Port requests and summary interrupt
  // ----------------------------------------
  logic [2:0] port_req;
  assign port_req = {|third_port_pending_flags, |second_port_pending_flags, |first_port_pending_flags};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_status <= RESET_IRQ;
    end else if (wr_lane0 && hit(avs_address, IDX_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~avs_writedata[2:0]) | port_req;
    end else begin
      irq_status <= irq_status | port_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_port_irq <= 1'b0;
      second_port_irq <= 1'b0;
      third_port_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      first_port_irq <= port_req[0];
      second_port_irq <= port_req[1];
      third_port_irq <= port_req[2];
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (hit(avs_address, IDX_FIRST_FLAGS)) next_rdata = first_port_pending_flags;
    if (hit(avs_address, IDX_SECOND_FLAGS)) next_rdata = second_port_pending_flags;
    if (hit(avs_address, IDX_THIRD_FLAGS)) next_rdata = third_port_pending_flags;
    if (hit(avs_address, IDX_CONTROL)) next_rdata = port_interrupt_control;
    if (hit(avs_address, IDX_SECOND_MASK)) next_rdata = second_port_pin_interrupt_mask;
    if (hit(avs_address, IDX_IRQ_STATUS)) next_rdata = {5'h00, irq_status};
    if (hit(avs_address, IDX_IRQ_MASK)) next_rdata = {5'h00, irq_mask};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !done) begin
      avs_readdata <= {24'h000000, next_rdata};
    end
  end
endmodule : ppei_top

// [test/ppei_properties.sv]
`timescale 1ns/100ps
module ppei_properties (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_readdata, // Data
  input wire logic avs_waitrequest, // Stall
  input wire logic first_port_irq, // Port 0
  input wire logic second_port_irq, // Port 1
  input wire logic third_port_irq, // Port 2
  input wire logic irq // Summary
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  chk_reset_idle: assert property (disable iff (1'b0) !rst_b |=> avs_waitrequest && !irq && !first_port_irq
    && !second_port_irq && !third_port_irq && avs_readdata == 32'h0) else $error("outputs not idle in reset");
  chk_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_rdata_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_first_clear: assert property ($fell(first_port_irq) |-> $past(avs_write, 2))
    else $error("port 0 request dropped without a write");
  chk_second_clear: assert property ($fell(second_port_irq) |-> $past(avs_write, 2))
    else $error("port 1 request dropped without a write");
  chk_third_clear: assert property ($fell(third_port_irq) |-> $past(avs_write, 2))
    else $error("port 2 request dropped without a write");
  chk_irq_clear: assert property ($fell(irq) |-> $past(avs_write, 2))
    else $error("interrupt dropped without a write");
  cover property ($rose(irq));
  cover property ($fell(third_port_irq));
  cover property (avs_read && !avs_waitrequest);
  cover property (avs_write && !avs_waitrequest);
endmodule : ppei_properties
bind ppei_top ppei_properties i_props (.clk, .rst_b, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .first_port_irq, .second_port_irq, .third_port_irq, .irq);

// [test/ppei_pin_model.sv]
`timescale 1ns/100ps
module ppei_pin_model (
  output logic [7:0] first_port_pins, // Port 0 pins
  output logic [7:0] second_port_pins, // Port 1 pins
  output logic [4:0] third_port_pins // Port 2 pins
);
  // Push-pull drivers, so a level always stands
  initial first_port_pins = 8'h00;
  initial second_port_pins = 8'h00;
  initial third_port_pins = 5'h00;
  task automatic drive(input int port, input logic [7:0] v);
    if (port == 0) first_port_pins <= v;
    else if (port == 1) second_port_pins <= v;
    else third_port_pins <= v[4:0];
  endtask : drive
endmodule : ppei_pin_model

// [test/ppei_top_test.sv]
`timescale 1ns/100ps
module ppei_top_test;
  import ppei_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, first_port_irq, second_port_irq, third_port_irq, irq;
  logic [7:0] p0, p1;
  logic [4:0] p2;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  ppei_pin_model i_pins (.first_port_pins(p0), .second_port_pins(p1), .third_port_pins(p2));
  ppei_top i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .first_port_pins(p0),
    .second_port_pins(p1), .third_port_pins(p2), .first_port_irq(first_port_irq),
    .second_port_irq(second_port_irq), .third_port_irq(third_port_irq), .irq(irq));
  initial begin
    forever #20 clk = ~clk;
  end
  // Whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("Errors %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Idle edge at the end keeps strobes from being driven twice in one step
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    avs_address <= {2'h0, idx};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask : rd_chk
  task automatic reg_scn;
    logic [7:0] regs [8] = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h90, 8'h91, 8'h00};
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    bus(1'b1, IDX_CONTROL, 8'hFF);
    rd_chk(IDX_CONTROL, 32'h7F);
    bus(1'b1, IDX_SECOND_MASK, 8'hA5);
    rd_chk(IDX_SECOND_MASK, 32'hA5);
    // Write without lane 0 must leave the mask alone
    avs_byteenable <= 4'h0;
    bus(1'b1, IDX_SECOND_MASK, 8'h3C);
    avs_byteenable <= 4'h1;
    rd_chk(IDX_SECOND_MASK, 32'hA5);
    bus(1'b1, 8'h00, 8'h5A);
    rd_chk(8'h00, 32'h0);
  endtask : reg_scn
  task automatic edge_case(input int p, input logic [7:0] ctl, msk, from, to, exp);
    logic [2:0] pi;
    bus(1'b1, IDX_CONTROL, ctl);
    bus(1'b1, IDX_SECOND_MASK, msk);
    i_pins.drive(p, from);
    repeat (8) @(posedge clk);
    bus(1'b1, IDX_FIRST_FLAGS + 8'(p), 8'h00);
    i_pins.drive(p, to);
    repeat (8) @(posedge clk);
    pi = {third_port_irq, second_port_irq, first_port_irq};
    chk({31'h0, pi[p]}, {31'h0, exp != 8'h00});
    rd_chk(IDX_FIRST_FLAGS + 8'(p), {24'h0, exp});
    bus(1'b1, IDX_FIRST_FLAGS + 8'(p), 8'h00);
    rd_chk(IDX_FIRST_FLAGS + 8'(p), 32'h0);
  endtask : edge_case
  task automatic first_port_scn;
    edge_case(0, 8'h18, 8'hFF, 8'h00, 8'hFF, 8'hFF);
    edge_case(0, 8'h19, 8'hFF, 8'hFF, 8'h00, 8'hFF);
    edge_case(0, 8'h08, 8'hFF, 8'h00, 8'hFF, 8'h0F);
    edge_case(0, 8'h10, 8'hFF, 8'h00, 8'hFF, 8'hF0);
    edge_case(0, 8'h18, 8'hFF, 8'hFF, 8'h00, 8'h00);
  endtask : first_port_scn
  task automatic other_ports_scn;
    edge_case(1, 8'h00, 8'hA5, 8'h00, 8'hFF, 8'hA5);
    edge_case(1, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'hFF);
    edge_case(2, 8'h20, 8'hFF, 8'h00, 8'h1F, 8'h1F);
    edge_case(2, 8'h00, 8'hFF, 8'h00, 8'h1F, 8'h00);
    edge_case(2, 8'h24, 8'hFF, 8'h1F, 8'h00, 8'h1F);
  endtask : other_ports_scn
  task automatic irq_scn;
    bus(1'b1, IDX_IRQ_STATUS, 8'h07);
    bus(1'b1, IDX_IRQ_MASK, 8'h02);
    edge_case(1, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01);
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    rd_chk(IDX_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    i_pins.drive(1, 8'h00);
    edge_case(1, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01);
    bus(1'b1, IDX_IRQ_MASK, 8'h02);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, IDX_IRQ_STATUS, 8'h02);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask : irq_scn
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    reg_scn();
    first_port_scn();
    other_ports_scn();
    irq_scn();
    stop_test();
  end
endmodule : ppei_top_test
